/* File: shift_reg_defs.svh */
// Offsets, field positions, reset values and widths of the shift register block.
`ifndef SHIFT_REG_DEFS_SVH
`define SHIFT_REG_DEFS_SVH

// ==========================================================
// Widths
`define REG_WIDTH       8
`define ADDR_W          32
`define CTRL_W          5
`define EDGES_W         16

// ==========================================================
// Register offsets (byte addresses)
`define OFS_CTRL        32'h0000_0000
`define OFS_PAR         32'h0000_0004
`define OFS_STATE       32'h0000_0008
`define OFS_EDGES       32'h0000_000C

// ==========================================================
// Control register fields
`define CTRL_SRC_SW     0
`define CTRL_LOAD_SEL_N 1
`define CTRL_CE_N       2
`define CTRL_SER_J      3
`define CTRL_SER_KN     4

// ==========================================================
// Reset values and responses
`define CTRL_RESET      5'h06
`define PAR_RESET       8'h00
`define EDGES_RESET     16'h0000
`define EDGES_STEP      16'h0001
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`endif

/* File: shift_reg_pkg.sv */
// Types shared by the shift register block.
package shift_reg_pkg;

   typedef enum logic [1:0] {
      MODE_HOLD  = 2'b00,
      MODE_SHIFT = 2'b01,
      MODE_LOAD  = 2'b10
   } mode_t;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_RESP = 1'b1
   } rd_state_t;

endpackage

/* File: reg_access_if.sv */
// Write path and register contents between the bus slave and the register bank.
`include "shift_reg_defs.svh"

interface reg_access_if;
   logic                    wrEn;
   logic [`ADDR_W-1:0]      wrAddr;
   logic [`REG_WIDTH-1:0]   wrData;
   logic                    wrByte0;
   logic [`CTRL_W-1:0]      ctrl;
   logic [`REG_WIDTH-1:0]   parData;

   modport bank (
      input  wrEn,
      input  wrAddr,
      input  wrData,
      input  wrByte0,
      output ctrl,
      output parData
   );

   modport bus (
      output wrEn,
      output wrAddr,
      output wrData,
      output wrByte0,
      input  ctrl,
      input  parData
   );
endinterface

/* File: reg_bank.sv */
// Software-written control and parallel data registers.
`include "shift_reg_defs.svh"

module reg_bank (
   input logic         ref_clk,
   input logic         rstn,
   reg_access_if.bank  bus
);

   logic [`CTRL_W-1:0]    ctrlReg;
   logic [`REG_WIDTH-1:0] parReg;

   // Only the low byte lane carries bits of these registers.
   wire ctrlHit = bus.wrEn && bus.wrByte0 && (bus.wrAddr == `OFS_CTRL);
   wire parHit  = bus.wrEn && bus.wrByte0 && (bus.wrAddr == `OFS_PAR);

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctrlReg <= `CTRL_RESET;
         parReg  <= `PAR_RESET;
      end else begin
         if (ctrlHit) begin
            ctrlReg <= bus.wrData[`CTRL_W-1:0];
         end
         if (parHit) begin
            parReg <= bus.wrData;
         end
      end
   end

   assign bus.ctrl    = ctrlReg;
   assign bus.parData = parReg;

endmodule // reg_bank

/* File: shift_stages.sv */
// The eight register stages with shift, load, hold and asynchronous clear.
`include "shift_reg_defs.svh"

module shift_stages (
   input  logic                  ref_clk,
   input  logic                  rstn,
   input  logic                  clear_n,
   input  shift_reg_pkg::mode_t  mode,
   input  logic                  serJ,
   input  logic                  serKn,
   input  logic [`REG_WIDTH-1:0] parIn,
   output logic [`REG_WIDTH-1:0] stages
);

   logic [`REG_WIDTH-1:0] shiftVec;
   logic [`REG_WIDTH-1:0] stagesNext;
   logic                  firstShift;

   always_comb begin
      unique case ({serJ, serKn})
         2'b11: firstShift = 1'b1;
         2'b00: firstShift = 1'b0;
         2'b10: firstShift = ~stages[0];
         2'b01: firstShift = stages[0];
      endcase
   end

   for (genvar i = 0; i < `REG_WIDTH; i++) begin : g_bit
      if (i == 0) begin : g_first
         assign shiftVec[i] = firstShift;
      end else begin : g_next
         assign shiftVec[i] = stages[i-1];
      end
   end

   always_comb begin
      unique case (mode)
         shift_reg_pkg::MODE_SHIFT: stagesNext = shiftVec;
         shift_reg_pkg::MODE_LOAD:  stagesNext = parIn;
         shift_reg_pkg::MODE_HOLD:  stagesNext = stages;
         default:                   stagesNext = stages;
      endcase
   end

   // The clear acts without the clock and wins over everything else.
   always_ff @(posedge ref_clk or negedge clear_n) begin
      if (!clear_n) begin
         stages <= `PAR_RESET;
      end else if (!rstn) begin
         stages <= `PAR_RESET;
      end else begin
         stages <= stagesNext;
      end
   end

endmodule // shift_stages

/* File: shift_reg_top.sv */
// Top level of the eight-stage parallel access shift register with AXI4-Lite registers.
`include "shift_reg_defs.svh"

// Operation
// - The block holds eight stages that drive the eight parallel outputs 0 to 7.
// - The active-low parallel-load select alone chooses between shift and load.
// - With the select high, stage 0 takes the serial J/K value and all stages move up one.
// - With the select low, each rising edge copies the eight parallel inputs to the stages.
// - Every transfer happens at the rising edge; inputs may change freely in between.
// - A low master clear zeroes all stages at once and overrides every other input.
// - A deasserted clock enable holds the contents unchanged across edges.
// - On shift, stage 0 is set, reset, toggled or kept for J/K of 11, 00, 10 and 01.
module shift_reg_top (
   input  logic                  ref_clk,
   input  logic                  rstn,
   input  logic                  clear_n,
   input  logic                  parallel_load_sel_n,
   input  logic                  clkEnN,
   input  logic                  serJ,
   input  logic                  serKN,
   input  logic [`REG_WIDTH-1:0] par_in,
   output logic [`REG_WIDTH-1:0] reg_out,
   input  logic [`ADDR_W-1:0]    awaddr,
   input  logic                  awvalid,
   output logic                  awready,
   input  logic [31:0]           wdata,
   input  logic [3:0]            wstrb,
   input  logic                  wvalid,
   output logic                  wready,
   output logic [1:0]            bresp,
   output logic                  bvalid,
   input  logic                  bready,
   input  logic [`ADDR_W-1:0]    araddr,
   input  logic                  arvalid,
   output logic                  arready,
   output logic [31:0]           rdata,
   output logic [1:0]            rresp,
   output logic                  rvalid,
   input  logic                  rready
);

   // ==========================================================
   // Register bank and effective controls

   reg_access_if regIf ();

   reg_bank uBank (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .bus     (regIf.bank)
   );

   logic [`CTRL_W-1:0]          ctrlBits;
   shift_reg_pkg::mode_t        mode;

   assign ctrlBits = regIf.ctrl;

   // Software may take over all pins except the master clear at once through the source bit.
   wire srcSw   = ctrlBits[`CTRL_SRC_SW];
   wire effSelN = srcSw ? ctrlBits[`CTRL_LOAD_SEL_N] : parallel_load_sel_n;
   wire effCeN  = srcSw ? ctrlBits[`CTRL_CE_N] : clkEnN;
   wire effJ    = srcSw ? ctrlBits[`CTRL_SER_J] : serJ;
   wire effKn   = srcSw ? ctrlBits[`CTRL_SER_KN] : serKN;
   wire [`REG_WIDTH-1:0] effPar = srcSw ? regIf.parData : par_in;

   assign mode = effCeN ? shift_reg_pkg::MODE_HOLD :
                 (effSelN ? shift_reg_pkg::MODE_SHIFT :
                  shift_reg_pkg::MODE_LOAD);

   shift_stages uCore (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .clear_n (clear_n),
      .mode    (mode),
      .serJ    (effJ),
      .serKn   (effKn),
      .parIn   (effPar),
      .stages  (reg_out)
   );

   // ==========================================================
   // AXI4-Lite write channel

   logic                haveAwReg;
   logic                haveWReg;
   logic                awreadyReg;
   logic                wreadyReg;
   logic                bvalidReg;
   logic [1:0]          brespReg;
   logic [`ADDR_W-1:0]  awaddrReg;
   logic [31:0]         wdataReg;
   logic [3:0]          wstrbReg;

   wire awTake = awvalid && awreadyReg;
   wire wTake  = wvalid && wreadyReg;
   wire wrGo   = haveAwReg && haveWReg && !bvalidReg;
   wire bDone  = bvalidReg && bready;

   wire [`ADDR_W-1:0] wrAddr = {awaddrReg[`ADDR_W-1:2], 2'b00};
   wire wrHitCtrl  = (wrAddr == `OFS_CTRL);
   wire wrHitPar   = (wrAddr == `OFS_PAR);
   wire wrHitState = (wrAddr == `OFS_STATE);
   wire wrHitEdges = (wrAddr == `OFS_EDGES);
   wire wrMapped   = wrHitCtrl || wrHitPar || wrHitState || wrHitEdges;

   assign regIf.wrEn    = wrGo;
   assign regIf.wrAddr  = wrAddr;
   assign regIf.wrData  = wdataReg[`REG_WIDTH-1:0];
   assign regIf.wrByte0 = wstrbReg[0];

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         haveAwReg  <= 1'b0;
         awreadyReg <= 1'b1;
         awaddrReg  <= '0;
      end else if (awTake) begin
         haveAwReg  <= 1'b1;
         awreadyReg <= 1'b0;
         awaddrReg  <= awaddr;
      end else if (bDone) begin
         haveAwReg  <= 1'b0;
         awreadyReg <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         haveWReg  <= 1'b0;
         wreadyReg <= 1'b1;
         wdataReg  <= '0;
         wstrbReg  <= '0;
      end else if (wTake) begin
         haveWReg  <= 1'b1;
         wreadyReg <= 1'b0;
         wdataReg  <= wdata;
         wstrbReg  <= wstrb;
      end else if (bDone) begin
         haveWReg  <= 1'b0;
         wreadyReg <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         bvalidReg <= 1'b0;
         brespReg  <= `RESP_OKAY;
      end else if (wrGo) begin
         bvalidReg <= 1'b1;
         brespReg  <= wrMapped ? `RESP_OKAY : `RESP_DECERR;
      end else if (bDone) begin
         bvalidReg <= 1'b0;
      end
   end

   assign awready = awreadyReg;
   assign wready  = wreadyReg;
   assign bvalid  = bvalidReg;
   assign bresp   = brespReg;

   // ==========================================================
   // Advance counter

   logic [`EDGES_W-1:0] edgeCntReg;

   // A clear in the same cycle as an advance leaves the count at one.
   wire edgeClr = wrGo && wrHitEdges;
   wire advance = (mode != shift_reg_pkg::MODE_HOLD) && clear_n;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         edgeCntReg <= `EDGES_RESET;
      end else if (edgeClr) begin
         edgeCntReg <= advance ? `EDGES_STEP : `EDGES_RESET;
      end else if (advance) begin
         edgeCntReg <= edgeCntReg + `EDGES_STEP;
      end
   end

   // ==========================================================
   // AXI4-Lite read channel

   shift_reg_pkg::rd_state_t rdState;
   logic                     arreadyReg;
   logic                     rvalidReg;
   logic [31:0]              rdataReg;
   logic [1:0]               rrespReg;

   wire arTake = arvalid && arreadyReg;
   wire rDone  = rvalidReg && rready;

   wire [`ADDR_W-1:0] rdAddr = {araddr[`ADDR_W-1:2], 2'b00};
   wire rdHitCtrl  = (rdAddr == `OFS_CTRL);
   wire rdHitPar   = (rdAddr == `OFS_PAR);
   wire rdHitState = (rdAddr == `OFS_STATE);
   wire rdHitEdges = (rdAddr == `OFS_EDGES);
   wire rdMapped   = rdHitCtrl || rdHitPar || rdHitState || rdHitEdges;

   wire [31:0] ctrlWord  = {27'h000_0000, ctrlBits};
   wire [31:0] parWord   = {24'h00_0000, regIf.parData};
   wire [31:0] stateWord = {22'h00_0000, effCeN, effSelN, reg_out};
   wire [31:0] edgesWord = {16'h0000, edgeCntReg};
   wire [31:0] rdMux = ({32{rdHitCtrl}} & ctrlWord) |
                       ({32{rdHitPar}} & parWord) |
                       ({32{rdHitState}} & stateWord) |
                       ({32{rdHitEdges}} & edgesWord);

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rdState    <= shift_reg_pkg::RD_IDLE;
         arreadyReg <= 1'b1;
         rvalidReg  <= 1'b0;
         rdataReg   <= '0;
         rrespReg   <= `RESP_OKAY;
      end else begin
         unique case (rdState)
            shift_reg_pkg::RD_IDLE: begin
               if (arTake) begin
                  rdState    <= shift_reg_pkg::RD_RESP;
                  arreadyReg <= 1'b0;
                  rvalidReg  <= 1'b1;
                  rdataReg   <= rdMux;
                  rrespReg   <= rdMapped ? `RESP_OKAY : `RESP_DECERR;
               end
            end
            shift_reg_pkg::RD_RESP: begin
               if (rDone) begin
                  rdState    <= shift_reg_pkg::RD_IDLE;
                  arreadyReg <= 1'b1;
                  rvalidReg  <= 1'b0;
               end
            end
         endcase
      end
   end

   assign arready = arreadyReg;
   assign rvalid  = rvalidReg;
   assign rdata   = rdataReg;
   assign rresp   = rrespReg;

   // ==========================================================
   // Assertions

   state_read_a : assert property (
      @(posedge ref_clk) disable iff (!rstn)
      arTake && rdHitState |=> rdataReg[`REG_WIDTH-1:0] == $past(reg_out)
   ) else $error("State read does not show the stages.");

   mode_pick_a : assert property (
      @(posedge ref_clk) disable iff (!rstn || !clear_n)
      !effCeN |=> reg_out == ($past(effSelN) ?
                  {$past(reg_out[6:0]), reg_out[0]} : $past(effPar))
   ) else $error("Select level did not pick shift or load.");

   shift_move_a : assert property (
      @(posedge ref_clk) disable iff (!rstn || !clear_n)
      mode == shift_reg_pkg::MODE_SHIFT |=> reg_out[7:1] == $past(reg_out[6:0])
   ) else $error("Stages did not move up on shift.");

   first_set_a : assert property (
      @(posedge ref_clk) disable iff (!rstn || !clear_n)
      mode == shift_reg_pkg::MODE_SHIFT && effJ == effKn |=> reg_out[0] == $past(effJ)
   ) else $error("Stage 0 not set or reset from equal J and K.");

   first_toggle_a : assert property (
      @(posedge ref_clk) disable iff (!rstn || !clear_n)
      mode == shift_reg_pkg::MODE_SHIFT && effJ && !effKn |=> $changed(reg_out[0])
   ) else $error("Stage 0 did not toggle.");

   first_keep_a : assert property (
      @(posedge ref_clk) disable iff (!rstn || !clear_n)
      mode == shift_reg_pkg::MODE_SHIFT && !effJ && effKn |=> $stable(reg_out[0])
   ) else $error("Stage 0 did not keep its value.");

   load_copy_a : assert property (
      @(posedge ref_clk) disable iff (!rstn || !clear_n)
      !effCeN && !effSelN |=> reg_out == $past(effPar)
   ) else $error("Parallel load did not copy the inputs.");

   edge_only_a : assert property (
      @(posedge ref_clk) disable iff (!rstn || !clear_n)
      $changed(reg_out) && $past(rstn) && $past(clear_n) |->
         $past(mode) != shift_reg_pkg::MODE_HOLD
   ) else $error("Stages changed without an active edge.");

   // A reset released at the starting edge has just zeroed the stages, so it must not count.
   hold_still_a : assert property (
      @(posedge ref_clk) disable iff (!rstn || !clear_n)
      rstn && effCeN ##1 effCeN |-> $stable(reg_out)
   ) else $error("Stages changed while the enable was high.");

   clear_zero_a : assert property (
      @(posedge ref_clk) disable iff (!rstn)
      !clear_n |-> reg_out == `PAR_RESET
   ) else $error("Clear did not zero the stages.");

   bresp_hold_a : assert property (
      @(posedge ref_clk) disable iff (!rstn)
      bvalidReg |=> ($past(bready) ? (!bvalidReg && awreadyReg && wreadyReg) :
                                     (bvalidReg && $stable(brespReg)))
   ) else $error("Write response not held or not released.");

endmodule // shift_reg_top

/* File: parallel_access_shift_register8_tb_top.sv */
// Self-checking testbench for the eight-stage parallel access shift register.
`include "shift_reg_defs.svh"

module parallel_access_shift_register8_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic                  ref_clk = 1'b0;
   logic                  rstn = 1'b0;
   logic                  clear_n = 1'b1;
   logic                  parallel_load_sel_n = 1'b1;
   logic                  clkEnN = 1'b1;
   logic                  serJ = 1'b0;
   logic                  serKN = 1'b0;
   logic [`REG_WIDTH-1:0] par_in = 8'h00;
   logic [`REG_WIDTH-1:0] reg_out;
   logic [`ADDR_W-1:0]    awaddr = 32'h0000_0000;
   logic                  awvalid = 1'b0;
   logic                  awready;
   logic [31:0]           wdata = 32'h0000_0000;
   logic [3:0]            wstrb = 4'h0;
   logic                  wvalid = 1'b0;
   logic                  wready;
   logic [1:0]            bresp;
   logic                  bvalid;
   logic                  bready = 1'b0;
   logic [`ADDR_W-1:0]    araddr = 32'h0000_0000;
   logic                  arvalid = 1'b0;
   logic                  arready;
   logic [31:0]           rdata;
   logic [1:0]            rresp;
   logic                  rvalid;
   logic                  rready = 1'b0;
   int                    miscompares = 0;
   int                    compares = 0;
   logic [7:0]            q;
   logic [31:0]           rd;
   logic [1:0]            rs;
   logic [1:0]            jkSeq [8] = '{2'b11, 2'b11, 2'b10, 2'b01, 2'b10, 2'b00, 2'b01, 2'b10};

   always #20 ref_clk = ~ref_clk;

   shift_reg_top dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .clear_n(clear_n),
      .parallel_load_sel_n(parallel_load_sel_n), .clkEnN(clkEnN),
      .serJ(serJ), .serKN(serKN), .par_in(par_in), .reg_out(reg_out),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );

   // ==========================================================
   // Verdict and comparisons
   task automatic test_done;
      begin
         if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask

   task automatic timeOut;
      begin
         miscompares++;
         $display("unexpected %0t bus answer missing", $time);
         test_done();
      end
   endtask

   task automatic chkOut(input logic [7:0] got, input logic [7:0] exp);
      begin
         compares++;
         if (got !== exp) begin
            miscompares++;
            $display("unexpected %0t reg_out %h expected %h", $time, got, exp);
         end
      end
   endtask

   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      begin
         compares++;
         if (got !== exp) begin
            miscompares++;
            $display("unexpected %0t read data %h expected %h", $time, got, exp);
         end
      end
   endtask

   task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
      begin
         compares++;
         if (got !== exp) begin
            miscompares++;
            $display("unexpected %0t response %h expected %h", $time, got, exp);
         end
      end
   endtask

   // ==========================================================
   // Bus cycles; each waits for the slave's answer under a bound.
   task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
      int   n;
      logic done;
      begin
         done = 1'b0;
         r = 2'h0;
         awaddr <= a;
         wdata <= d;
         wstrb <= s;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         for (n = 0; n < 50 && !done; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
               r = bresp;
               bready <= 1'b0;
               done = 1'b1;
            end
         end
         if (!done) timeOut();
         #1;
      end
   endtask

   task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic done;
      begin
         done = 1'b0;
         d = 32'h0000_0000;
         r = 2'h0;
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         for (n = 0; n < 50 && !done; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
               d = rdata;
               r = rresp;
               rready <= 1'b0;
               done = 1'b1;
            end
         end
         if (!done) timeOut();
         #1;
      end
   endtask

   task automatic expRead(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      begin
         axiRead(a, rd, rs);
         chkWord(rd, d);
         chkResp(rs, r);
      end
   endtask

   // One clock edge on the pins, checked against the reference register q.
   task automatic step(input logic sel, input logic ce, input logic [1:0] jk,
                       input logic [7:0] p);
      logic f;
      begin
         parallel_load_sel_n <= sel;
         clkEnN <= ce;
         serJ <= jk[1];
         serKN <= jk[0];
         par_in <= p;
         @(posedge ref_clk);
         case (jk)
            2'b11: f = 1'b1;
            2'b00: f = 1'b0;
            2'b10: f = ~q[0];
            default: f = q[0];
         endcase
         if (!ce) q = sel ? {q[6:0], f} : p;
         #1 chkOut(reg_out, q);
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      q = 8'h00;
      #1 chkOut(reg_out, 8'h00);
      expRead(`OFS_CTRL, 32'h0000_0006, `RESP_OKAY);
      expRead(`OFS_PAR, 32'h0000_0000, `RESP_OKAY);
      expRead(`OFS_EDGES, 32'h0000_0000, `RESP_OKAY);
      for (int i = 0; i < 8; i++) step(1'b1, 1'b0, jkSeq[i], 8'hFF);
      step(1'b0, 1'b0, 2'b11, 8'hA5);
      step(1'b0, 1'b0, 2'b11, 8'h3C);
      step(1'b0, 1'b1, 2'b10, 8'hFF);
      step(1'b1, 1'b1, 2'b10, 8'hFF);
      step(1'b1, 1'b0, 2'b11, 8'h00);
      step(1'b1, 1'b1, 2'b00, 8'h00);
      expRead(`OFS_EDGES, 32'h0000_000B, `RESP_OKAY);
      axiWrite(`OFS_EDGES, 32'h0000_0000, 4'hF, rs);
      chkResp(rs, `RESP_OKAY);
      expRead(`OFS_EDGES, 32'h0000_0000, `RESP_OKAY);
      axiWrite(`OFS_STATE, 32'h0000_00AA, 4'hF, rs);
      chkResp(rs, `RESP_OKAY);
      axiRead(`OFS_STATE, rd, rs);
      // Both pins are high here, so the effective enable and select bits read back as ones.
      chkWord(rd, {24'h00_0003, q});
      // Register fields replace the pins while the source bit is set.
      axiWrite(`OFS_PAR, 32'h0000_005A, 4'hF, rs);
      axiWrite(`OFS_CTRL, 32'h0000_0001, 4'hF, rs);
      repeat (2) @(posedge ref_clk);
      #1 chkOut(reg_out, 8'h5A);
      axiWrite(`OFS_CTRL, 32'h0000_001B, 4'hF, rs);
      repeat (10) @(posedge ref_clk);
      #1 chkOut(reg_out, 8'hFF);
      parallel_load_sel_n <= 1'b0;
      clkEnN <= 1'b0;
      axiWrite(`OFS_CTRL, 32'h0000_0007, 4'hF, rs);
      repeat (3) @(posedge ref_clk);
      #1 chkOut(reg_out, 8'hFF);
      axiWrite(`OFS_CTRL, 32'h0000_0006, 4'hF, rs);
      repeat (2) @(posedge ref_clk);
      #1 chkOut(reg_out, 8'h00);
      clkEnN <= 1'b1;
      q = 8'h00;
      axiWrite(`OFS_PAR, 32'h0000_00FF, 4'h0, rs);
      chkResp(rs, `RESP_OKAY);
      expRead(`OFS_PAR, 32'h0000_005A, `RESP_OKAY);
      axiWrite(32'h0000_0020, 32'h0000_0001, 4'hF, rs);
      chkResp(rs, `RESP_DECERR);
      expRead(32'h0000_0010, 32'h0000_0000, `RESP_DECERR);
      // Asynchronous clear in mid-cycle, held across loading edges.
      step(1'b0, 1'b0, 2'b00, 8'hC3);
      #5 par_in <= 8'h18;
      #1 chkOut(reg_out, q);
      #5 clear_n <= 1'b0;
      #1 chkOut(reg_out, 8'h00);
      repeat (2) @(posedge ref_clk);
      #1 chkOut(reg_out, 8'h00);
      clear_n <= 1'b1;
      step(1'b0, 1'b0, 2'b00, 8'h18);
      clkEnN <= 1'b1;
      rstn <= 1'b0;
      @(posedge ref_clk);
      rstn <= 1'b1;
      #1 chkOut(reg_out, 8'h00);
      expRead(`OFS_CTRL, 32'h0000_0006, `RESP_OKAY);
      test_done();
   end
endmodule // parallel_access_shift_register8_tb_top
